/* File: shared/reset_boot_pkg.sv */
// ==========================================================================
// Constants shared by the reset and boot mode logic.
// ==========================================================================
package reset_boot_pkg;
  // Least external reset low time, in CPU clocks.
  localparam int unsigned RESET_IN_MIN_CYCLES = 8;
  // Reset output stretch after the last reset source clears, in CPU clocks.
  localparam int unsigned RESET_OUT_STRETCH_CYCLES = 1024;
  // Clock boot select encodings.
  localparam logic [1:0] CLK_SEL_EXT_OR_OCO = 2'h0;
  localparam logic [1:0] CLK_SEL_CRYSTAL = 2'h1;
  localparam logic [1:0] CLK_SEL_PLL_EXT = 2'h2;
  localparam logic [1:0] CLK_SEL_PLL_CRYSTAL = 2'h3;
  // Clock source encodings on the clockSource output.
  localparam logic [1:0] SRC_EXTERNAL = 2'h0;
  localparam logic [1:0] SRC_ON_CHIP = 2'h1;
  localparam logic [1:0] SRC_CRYSTAL = 2'h2;
  // AHB-Lite register map (byte addresses).
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  // Status word field positions.
  localparam int unsigned ST_SEL_LSB = 0;
  localparam int unsigned ST_PIN_BIT = 2;
  localparam int unsigned ST_PLL_BIT = 3;
  localparam int unsigned ST_SRC_LSB = 4;
  localparam int unsigned ST_RSV_BIT = 6;
  localparam int unsigned ST_FLASH_BIT = 7;
  localparam int unsigned ST_RSTOUT_BIT = 8;
  // Control word: bit 0 requests a software reset.
  localparam int unsigned CT_SWRST_BIT = 0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : reset_boot_pkg

/* File: src/reset_and_boot_mode_select.sv */
// Behaviour
// - Reset input held low at least 8 clocks resets CPU and peripherals at once.
// - Reset output stays low exactly 1024 clocks after every reset source clears.
// - Select 00: PLL off; crystal pin 0 external oscillator, 1 on-chip oscillator.
// - Select 01: PLL off, crystal oscillator clocks the chip, crystal pin ignored.
// - Select 10 with crystal pin 0: PLL on, external reference; pin 1 reserved.
// - Select 11: PLL on, crystal reference, crystal pin ignored.
// - Low select bit 0 makes crystal pin an input sampled for mode selection.
// - Boot config asserted, test negated at reset end enters serial flash mode.
// - System clock output is a copy of the internal system clock.
// - Clock input pin used in every mode except on-chip oscillator mode.
`timescale 1ns/1ps
`default_nettype none
module reset_and_boot_mode_select
  import reset_boot_pkg::*;
#(
  parameter int unsigned STRETCH_CYCLES = RESET_OUT_STRETCH_CYCLES
)(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reset_input_n,
  input wire logic [1:0] clock_boot_select,
  input wire logic crystal_output_pin_in,
  output logic crystal_output_pin_out,
  output logic crystal_output_pin_oe,
  input wire logic crystal_drive,
  input wire logic boot_config_n,
  input wire logic test_pin,
  input wire logic system_clock,
  output logic system_clock_output,
  output logic reset_output_n,
  output logic core_reset_n,
  output logic pll_enable,
  output logic [1:0] clock_source,
  output logic clock_input_pin_used,
  output logic mode_reserved,
  output logic serial_flash_mode,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  // ========================================================================
  // Pin synchronisers
  // ========================================================================
  logic [1:0] rstInSync_r;
  logic [1:0] selSync0_r;
  logic [1:0] selSync1_r;
  logic [1:0] pinSync0_r;
  logic [1:0] pinSync1_r;
  logic [1:0] bootSync0_r;
  logic [1:0] bootSync1_r;
  logic [1:0] testSync_r;

  // Two flops on every pin; only the second stage is read below.
  // Reset values match each pin's idle level, so no false edge follows power-on reset.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstInSync_r <= 2'h3;
      selSync0_r <= 2'h0;
      selSync1_r <= 2'h0;
      pinSync0_r <= 2'h0;
      pinSync1_r <= 2'h0;
      bootSync0_r <= 2'h1;
      bootSync1_r <= 2'h1;
      testSync_r <= 2'h0;
    end
    else
    begin
      rstInSync_r <= {rstInSync_r[0], reset_input_n};
      selSync0_r <= clock_boot_select;
      selSync1_r <= selSync0_r;
      pinSync0_r <= {1'b0, crystal_output_pin_in};
      pinSync1_r <= pinSync0_r;
      bootSync0_r <= {1'b0, boot_config_n};
      bootSync1_r <= bootSync0_r;
      testSync_r <= {testSync_r[0], test_pin};
    end
  end

  // ========================================================================
  // Reset input qualification
  // ========================================================================
  localparam int unsigned LOW_W = $clog2(RESET_IN_MIN_CYCLES + 1);
  logic [LOW_W-1:0] lowCount_r;
  logic extReset_r;
  logic swReset_r;
  logic resetActive;

  // A glitch shorter than the minimum low time is ignored; once the count
  // is reached the reset takes effect on that same edge.
  // The two synchroniser flops add a further two clocks ahead of the count.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lowCount_r <= '0;
      extReset_r <= 1'b0;
    end
    else if (rstInSync_r[1])
    begin
      lowCount_r <= '0;
      extReset_r <= 1'b0;
    end
    else if (lowCount_r < LOW_W'(RESET_IN_MIN_CYCLES - 1))
    begin
      lowCount_r <= lowCount_r + 1'b1;
    end
    else
    begin
      extReset_r <= 1'b1;
    end
  end

  // Either source holds the core; the stretch restarts from whichever clears last.
  assign resetActive = extReset_r || swReset_r;

  // ========================================================================
  // Reset output stretch
  // ========================================================================
  localparam int unsigned STR_W = $clog2(STRETCH_CYCLES + 1);
  logic [STR_W-1:0] stretch_r;
  logic resetOut_r;

  // The count restarts whenever any source is active, so the output is
  // released exactly STRETCH_CYCLES clocks after the last source clears.
  // A reset arriving mid-stretch simply starts the count again.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stretch_r <= '0;
      resetOut_r <= 1'b0;
    end
    else if (resetActive)
    begin
      stretch_r <= '0;
      resetOut_r <= 1'b0;
    end
    else if (!resetOut_r)
    begin
      if (stretch_r == STR_W'(STRETCH_CYCLES - 1))
      begin
        resetOut_r <= 1'b1;
      end
      else
      begin
        stretch_r <= stretch_r + 1'b1;
      end
    end
  end

  // The reset output comes from a flop, so it never glitches while sources change.
  assign reset_output_n = resetOut_r;
  assign core_reset_n = ~resetActive;

  // ========================================================================
  // Mode latch
  // ========================================================================
  logic [1:0] selLatch_r;
  logic pinLatch_r;
  logic flashMode_r;
  logic resetOutPrev_r;
  logic releaseEdge;

  // High for one clock, the first clock after the reset output lets go.
  assign releaseEdge = resetOut_r && !resetOutPrev_r;

  // Straps are tracked while reset is held and frozen on release, so a
  // pin moving later never changes the clock tree under running code.
  // Flash mode is decided once, on the first clock after release.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resetOutPrev_r <= 1'b0;
      selLatch_r <= CLK_SEL_EXT_OR_OCO;
      pinLatch_r <= 1'b0;
      flashMode_r <= 1'b0;
    end
    else
    begin
      resetOutPrev_r <= resetOut_r;
      if (!resetOut_r)
      begin
        selLatch_r <= selSync1_r;
        pinLatch_r <= pinSync1_r[0];
      end
      if (releaseEdge)
      begin
        flashMode_r <= !bootSync1_r[0] && !testSync_r[1];
      end
      else if (!resetOut_r)
      begin
        flashMode_r <= 1'b0;
      end
    end
  end

  // Programming mode holds until the next reset; the flash port sees only this level.
  assign serial_flash_mode = flashMode_r;

  // ========================================================================
  // Clock mode decode
  // ========================================================================
  // The mode word packs the reserved flag in its top bit, the PLL request
  // below it and the clock source in the low two bits.
  // Keeping the decode in one function lets the status read and the clock tree agree.
  function automatic logic [3:0] decodeMode(input logic [1:0] sel, input logic pin);
    logic [3:0] res;
    res = {1'b0, 1'b0, SRC_EXTERNAL};
    case (sel)
      CLK_SEL_EXT_OR_OCO: res = {1'b0, 1'b0, pin ? SRC_ON_CHIP : SRC_EXTERNAL};
      CLK_SEL_CRYSTAL: res = {1'b0, 1'b0, SRC_CRYSTAL};
      CLK_SEL_PLL_EXT: res = {pin, 1'b1, SRC_EXTERNAL};
      CLK_SEL_PLL_CRYSTAL: res = {1'b0, 1'b1, SRC_CRYSTAL};
      default: res = {1'b0, 1'b0, SRC_EXTERNAL};
    endcase
    return res;
  endfunction : decodeMode

  // Decoded from the latched straps only, never from the live pins.
  logic [3:0] modeWord;
  assign modeWord = decodeMode(selLatch_r, pinLatch_r);

  logic pllEn_r;
  logic [1:0] src_r;
  logic rsv_r;

  // Registered so the clock tree controls never glitch on decode.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pllEn_r <= 1'b0;
      src_r <= SRC_EXTERNAL;
      rsv_r <= 1'b0;
    end
    else
    begin
      rsv_r <= modeWord[3];
      pllEn_r <= modeWord[2] && !modeWord[3];
      src_r <= modeWord[1:0];
    end
  end

  // Clock tree controls straight from their flops; the clock input use flag is decoded from the source flop.
  // The reserved combination keeps the PLL off rather than guessing a reference.
  assign pll_enable = pllEn_r;
  assign clock_source = src_r;
  assign mode_reserved = rsv_r;
  assign clock_input_pin_used = (src_r != SRC_ON_CHIP);

  // Crystal pin is released as an input when the low select bit is zero.
  assign crystal_output_pin_oe = selLatch_r[0];
  assign crystal_output_pin_out = selLatch_r[0] & crystal_drive;

  // Straight copy; a flop here would halve the frequency.
  assign system_clock_output = system_clock;

  // ========================================================================
  // AHB-Lite slave
  // ========================================================================
  logic wrPend_r;
  logic [7:0] addrPend_r;
  logic [31:0] rdata_r;
  logic accept;

  // Only single NONSEQ transfers are taken, whatever hsize says; other transfer types are ignored.
  // The slave never stalls and never errors, so every answer is OKAY.
  assign accept = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;

  // Zero wait states: read data is registered at the address phase.
  // An unmapped address reads as zero.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPend_r <= 1'b0;
      addrPend_r <= 8'h00;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      wrPend_r <= accept && hwrite;
      addrPend_r <= haddr;
      if (accept && !hwrite)
      begin
        rdata_r <= 32'h0000_0000;
        if (haddr == ADDR_STATUS)
        begin
          rdata_r[ST_SEL_LSB +: 2] <= selLatch_r;
          rdata_r[ST_PIN_BIT] <= pinLatch_r;
          rdata_r[ST_PLL_BIT] <= pllEn_r;
          rdata_r[ST_SRC_LSB +: 2] <= src_r;
          rdata_r[ST_RSV_BIT] <= rsv_r;
          rdata_r[ST_FLASH_BIT] <= flashMode_r;
          rdata_r[ST_RSTOUT_BIT] <= resetOut_r;
        end
      end
    end
  end

  // A written control bit raises a software reset source; it clears itself
  // once the reset reaches the output, so the stretch applies to it too.
  // Writing zero to the control bit has no effect.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      swReset_r <= 1'b0;
    end
    else if (wrPend_r && addrPend_r == ADDR_CONTROL && hwdata[CT_SWRST_BIT])
    begin
      swReset_r <= 1'b1;
    end
    else if (!resetOut_r)
    begin
      swReset_r <= 1'b0;
    end
  end

  // Inputs and flop bits that carry no meaning here are folded together,
  // so that leaving them unread is a visible decision.
  logic unusedBits;
  assign unusedBits = ^{hsize, hwdata[31:1], pinSync1_r[1], bootSync1_r[1]};

endmodule : reset_and_boot_mode_select
`default_nettype wire

/* File: bench/reset_boot_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Board reset source and flash programmer straps.
// ==========================================================================
module reset_boot_partner (
  input wire logic ref_clk,
  output logic reset_input_n,
  output logic boot_config_n,
  output logic test_pin
);
  // Idle board: reset released, no programmer request, test pin tied low.
  initial
  begin
    reset_input_n = 1'h1;
    boot_config_n = 1'h1;
    test_pin = 1'h0;
  end
  // Pulls the board reset low for n clocks; fewer than 8 models a glitch.
  task automatic pulse(input int n);
    reset_input_n <= 1'h0;
    repeat (n) @(posedge ref_clk);
    reset_input_n <= 1'h1;
  endtask : pulse
  // Programmer straps, held across the next reset release.
  task automatic strap(input logic cfgN, input logic tst);
    boot_config_n <= cfgN;
    test_pin <= tst;
  endtask : strap
endmodule : reset_boot_partner
`default_nettype wire

/* File: bench/reset_and_boot_mode_select_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module reset_boot_checker
  import reset_boot_pkg::*;
#(
  parameter int unsigned STRETCH_CYCLES = RESET_OUT_STRETCH_CYCLES
)(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reset_input_n,
  input wire logic [1:0] clock_boot_select,
  input wire logic crystal_output_pin_in,
  input wire logic crystal_output_pin_out,
  input wire logic crystal_output_pin_oe,
  input wire logic crystal_drive,
  input wire logic boot_config_n,
  input wire logic test_pin,
  input wire logic system_clock,
  input wire logic system_clock_output,
  input wire logic reset_output_n,
  input wire logic core_reset_n,
  input wire logic pll_enable,
  input wire logic [1:0] clock_source,
  input wire logic clock_input_pin_used,
  input wire logic mode_reserved,
  input wire logic serial_flash_mode
);
  logic [1:0] selSeen;
  logic pinSeen;
  logic flashSeen;
  logic [1:0] hiPipe;
  logic [10:0] stretchCnt;
  wire live = reset_output_n && (hiPipe == 2'h3);
  wire rsvExp = (selSeen == CLK_SEL_PLL_EXT) && pinSeen;
  wire [1:0] expSrc = selSeen[0] ? SRC_CRYSTAL : (pinSeen && !selSeen[1]) ? SRC_ON_CHIP : SRC_EXTERNAL;
  // Straps mirrored while held in reset; frozen once the reset output lets go.
  always_ff @(posedge ref_clk)
  begin
    if (!reset_output_n)
    begin
      selSeen <= clock_boot_select;
      pinSeen <= crystal_output_pin_in;
      flashSeen <= !boot_config_n && !test_pin;
    end
  end
  // Mode outputs settle one edge after the latch, so checks wait two clocks.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      hiPipe <= 2'h0;
    else
      hiPipe <= {hiPipe[0], reset_output_n};
  end
  // Counts clocks with the core out of reset but the reset output still low.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      stretchCnt <= 11'h000;
    else if (!core_reset_n)
      stretchCnt <= 11'h000;
    else if (!reset_output_n)
      stretchCnt <= stretchCnt + 11'h001;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_sysclk; system_clock_output == system_clock; endproperty
  property p_crystal_output_pin; crystal_output_pin_out == (crystal_output_pin_oe && crystal_drive)
    && (!live || crystal_output_pin_oe == selSeen[0]); endproperty
  property p_used; clock_input_pin_used == (clock_source != SRC_ON_CHIP); endproperty
  property p_ext; !reset_input_n [*8] |-> ##[1:3] !core_reset_n; endproperty
  property p_stretch; $rose(reset_output_n) |-> stretchCnt == STRETCH_CYCLES; endproperty
  property p_hold; !core_reset_n |=> !reset_output_n; endproperty
  property p_pll; live |-> pll_enable == (selSeen[1] && !rsvExp); endproperty
  property p_src; live && !rsvExp |-> clock_source == expSrc; endproperty
  property p_rsv; live |-> mode_reserved == rsvExp; endproperty
  property p_flash; live |-> serial_flash_mode == flashSeen; endproperty
  property p_frozen; live |-> $stable({pll_enable, clock_source, mode_reserved, serial_flash_mode}); endproperty
  a_sysclk: assert property (p_sysclk) else $error("clock output differs from system clock");
  a_crystal_output_pin: assert property (p_crystal_output_pin) else $error("crystal pin drive wrong");
  a_used: assert property (p_used) else $error("clock input use wrong");
  a_ext: assert property (p_ext) else $error("board reset did not reset core");
  a_stretch: assert property (p_stretch) else $error("reset output stretch wrong");
  a_hold: assert property (p_hold) else $error("reset output high during core reset");
  a_pll: assert property (p_pll) else $error("pll enable wrong");
  a_src: assert property (p_src) else $error("clock source wrong");
  a_rsv: assert property (p_rsv) else $error("reserved flag wrong");
  a_flash: assert property (p_flash) else $error("flash mode wrong");
  a_frozen: assert property (p_frozen) else $error("mode changed after latch");
  c_core: cover property ($fell(core_reset_n));
  c_flash: cover property (live && serial_flash_mode);
  c_rsv: cover property (live && mode_reserved);
endmodule : reset_boot_checker
bind reset_and_boot_mode_select reset_boot_checker #(.STRETCH_CYCLES(STRETCH_CYCLES)) reset_boot_checker_inst (
  .ref_clk, .rst_n, .reset_input_n, .clock_boot_select, .crystal_output_pin_in, .crystal_output_pin_out,
  .crystal_output_pin_oe, .crystal_drive, .boot_config_n, .test_pin, .system_clock, .system_clock_output,
  .reset_output_n, .core_reset_n, .pll_enable, .clock_source, .clock_input_pin_used, .mode_reserved,
  .serial_flash_mode);
`default_nettype wire

/* File: bench/tb_reset_and_boot_mode_select.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_reset_and_boot_mode_select
  import reset_boot_pkg::*;
  ;
  localparam int unsigned S = 16;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [1:0] sel = 2'h0;
  logic xin = 1'h0;
  logic drive = 1'h0;
  logic sysClk = 1'h0;
  logic hsel = 1'h0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h00000000;
  wire [31:0] hrdata;
  wire [1:0] src;
  wire hreadyout, hresp, xout, xoe, sysOut, ron, coreN, pll, rsv, flash, used, rin, cfgN, tst;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int falls = 0;
  reset_boot_partner reset_boot_partner_inst (.ref_clk(ref_clk), .reset_input_n(rin), .boot_config_n(cfgN),
    .test_pin(tst));
  reset_and_boot_mode_select #(.STRETCH_CYCLES(S)) reset_and_boot_mode_select_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .reset_input_n(rin), .clock_boot_select(sel), .crystal_output_pin_in(xin),
    .crystal_output_pin_out(xout), .crystal_output_pin_oe(xoe), .crystal_drive(drive), .boot_config_n(cfgN),
    .test_pin(tst), .system_clock(sysClk), .system_clock_output(sysOut), .reset_output_n(ron),
    .core_reset_n(coreN), .pll_enable(pll), .clock_source(src), .clock_input_pin_used(used),
    .mode_reserved(rsv), .serial_flash_mode(flash), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));
  // Clock, and an internal clock plus oscillator drive that toggle off it.
  initial forever #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) {sysClk, drive} <= {~sysClk, sysClk};
  always @(negedge coreN) falls++;
  // A hang ends the run as a mismatch rather than stalling forever.
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One single AHB-Lite word transfer; read data is taken at the data phase edge.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask : ahb
  // Waits out a reset, counting clocks from core release to reset output release.
  // A core reset that has not yet begun is waited for first, so a short pulse is not missed.
  task automatic settle(input logic waitCore, output int n);
    n = 0;
    if (waitCore)
    begin
      do @(negedge ref_clk); while (coreN !== 1'h0);
    end
    while (coreN !== 1'h1 || ron !== 1'h1)
    begin
      @(negedge ref_clk);
      if (coreN === 1'h1 && ron !== 1'h1)
        n++;
    end
    repeat (4) @(posedge ref_clk);
  endtask : settle
  task automatic expect_mode(input logic [1:0] s, input logic p, input logic f);
    logic r;
    logic [1:0] e;
    logic [31:0] q;
    r = (s == CLK_SEL_PLL_EXT) && p;
    e = s[0] ? SRC_CRYSTAL : (p && !s[1]) ? SRC_ON_CHIP : SRC_EXTERNAL;
    check("pll", pll, s[1] && !r);
    check("reserved", rsv, r);
    check("oe", xoe, s[0]);
    check("flash", flash, f);
    check("system_clock_output", sysOut, sysClk);
    check("xout", xout, s[0] & drive);
    if (!r)
    begin
      check("source", src, e);
      check("used", used, e != SRC_ON_CHIP);
    end
    ahb(1'h0, ADDR_STATUS, 32'h0, q);
    check("okay", hresp, 1'h0);
    check("status", q & (r ? 32'h1CF : 32'h1FF), {23'h0, 1'h1, f, r, r ? 2'h0 : e, s[1] && !r, p, s});
  endtask : expect_mode
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // Main sequence: every strap mode, pin 0 through a software reset and pin 1 through a board reset, then flash and glitch cases.
  initial
  begin
    logic [31:0] q;
    int n;
    int f;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'h1;
    settle(1'h0, n);
    check("stretch", n, S);
    expect_mode(2'h0, 1'h0, 1'h0);
    for (int i = 0; i < 8; i++)
    begin
      sel <= i[2:1];
      xin <= i[0];
      if (i[0])
        reset_boot_partner_inst.pulse(12);
      else
        ahb(1'h1, ADDR_CONTROL, 32'h1, q);
      settle(1'h1, n);
      check("stretch", n, S);
      expect_mode(i[2:1], i[0], 1'h0);
      sel <= ~sel;
      xin <= ~xin;
      repeat (4) @(posedge ref_clk);
      expect_mode(i[2:1], i[0], 1'h0);
      $display("mode test %0d done", i);
    end
    for (int t = 0; t < 2; t++)
    begin
      reset_boot_partner_inst.strap(1'h0, t[0]);
      reset_boot_partner_inst.pulse(8);
      settle(1'h1, n);
      check("stretch", n, S);
      expect_mode(sel, xin, !t[0]);
      $display("flash test %0d done", t);
    end
    f = falls;
    reset_boot_partner_inst.pulse(7);
    repeat (15) @(posedge ref_clk);
    check("glitch", falls, f);
    ahb(1'h0, 8'h08, 32'h0, q);
    check("unmapped", q, 32'h0);
    $display("glitch and bus test done");
    tally_and_finish();
  end
endmodule : tb_reset_and_boot_mode_select
`default_nettype wire
